//--- hw/rsc_pkg.sv
// shared constants and carrier types of the reset source controller
package rsc_pkg;

  // register addresses on the special-function register port
  localparam logic [7:0] ADDR_MON_CTRL = 8'hFF;
  localparam logic [7:0] ADDR_RST_SRC = 8'hEF;

  // supply_monitor_control fields
  localparam int MON_EN_BIT = 7;
  localparam int MON_STAT_BIT = 6;

  // reset_source_register fields, also used as cause codes
  localparam logic [2:0] SRC_PIN = 3'h0;
  localparam logic [2:0] SRC_POR = 3'h1;
  localparam logic [2:0] SRC_CLK = 3'h2;
  localparam logic [2:0] SRC_WD = 3'h3;
  localparam logic [2:0] SRC_SW = 3'h4;
  localparam logic [2:0] SRC_CMP = 3'h5;
  localparam logic [2:0] SRC_FLASH = 3'h6;
  localparam logic [2:0] SRC_USB = 3'h7;

  // timing at the system clock
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int POR_DELAY_NS = 300_000;
  localparam int POR_DELAY_CYC = POR_DELAY_NS / CLK_NS;
  localparam int MIN_HOLD_NS = 80;
  localparam int MIN_HOLD_CYC = (MIN_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CLK_LOSS_NS = 2_000;
  localparam int CLK_LOSS_CYC = CLK_LOSS_NS / CLK_NS;
  localparam int WD_DIV = 12;
  localparam int WD_TICKS = 255;

  typedef enum logic [1:0] {
    S_RUN = 2'b00,
    S_HOLD = 2'b01,
    S_POR = 2'b10
  } mode_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_bus_t;

  typedef struct packed {
    logic addr_over;
    logic sec_block;
    logic wr_attempt;
  } flash_evt_t;

  typedef struct packed {
    logic bus_reset;
    logic func_en;
    logic vbus;
  } usb_evt_t;

endpackage

//--- hw/watchdog_timer.sv
// watchdog timer ticking at the system clock divided by twelve
`timescale 1ns/1ns
module watchdog_timer import rsc_pkg::*; #(
  parameter int DIV = WD_DIV,
  parameter int TICKS = WD_TICKS
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic restart,
  input wire logic kick,
  input wire logic disable_wd,
  output logic overflow
);

  typedef struct packed {
    logic en;
    logic [3:0] div;
    logic [7:0] ticks;
    logic ovf;
  } wd_st_t;

  wd_st_t st_r;
  wd_st_t st_nxt;
  logic tick;

  assign tick = (st_r.div == 4'(DIV - 1));

  // divider gives a one-cycle enable, counter runs on it
  always_comb begin
    st_nxt = st_r;
    st_nxt.ovf = 1'b0;
    st_nxt.div = tick ? 4'h0 : st_r.div + 4'h1;
    if (restart) begin
      st_nxt.en = 1'b1; // RULE15
      st_nxt.div = 4'h0;
      st_nxt.ticks = 8'h00;
    end else if (disable_wd) begin
      st_nxt.en = 1'b0;
      st_nxt.ticks = 8'h00;
    end else if (kick) begin
      st_nxt.ticks = 8'h00;
    end else if (st_r.en && tick) begin
      if (st_r.ticks == 8'(TICKS)) begin
        st_nxt.ovf = 1'b1; // RULE15
        st_nxt.ticks = 8'h00;
      end else begin
        st_nxt.ticks = st_r.ticks + 8'h01;
      end
    end
  end

  // enabled straight out of the master reset as after any other
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= '{en: 1'b1, div: 4'h0, ticks: 8'h00, ovf: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign overflow = st_r.ovf;

endmodule

//--- hw/clock_loss_detector.sv
// detector for a monitored clock stuck high or low
`timescale 1ns/1ns
module clock_loss_detector import rsc_pkg::*; #(
  parameter int TIMEOUT = CLK_LOSS_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic enable,
  input wire logic clk_probe,
  output logic lost
);

  typedef struct packed {
    logic probe_q;
    logic [7:0] idle;
    logic lost;
  } cl_st_t;

  cl_st_t st_r;
  cl_st_t st_nxt;

  // any edge on the probe re-arms the one-shot
  always_comb begin
    st_nxt = st_r;
    st_nxt.probe_q = clk_probe;
    st_nxt.lost = 1'b0;
    if (!enable || (clk_probe != st_r.probe_q)) begin
      st_nxt.idle = 8'h00;
    end else if (st_r.idle == 8'(TIMEOUT)) begin
      st_nxt.lost = 1'b1; // RULE9
      st_nxt.idle = 8'h00;
    end else begin
      st_nxt.idle = st_r.idle + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= '{probe_q: 1'b0, idle: 8'h00, lost: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lost = st_r.lost;

endmodule

//--- hw/reset_source_controller.sv
// reset source collection, cause capture and supply monitor control
//
// Behaviour
// RULE1 - supply below threshold with monitor active drives pin low, holds core
// RULE2 - monitor enable set by power-on only, kept by all other resets
// RULE3 - software enables monitor, waits, then selects it as source
// RULE4 - bit 7 switches monitor; it resets only when also selected
// RULE5 - bit 6 reads live monitor output, 1 when supply above threshold
// RULE6 - bits 5:0 of monitor control read zero, writes ignored
// RULE7 - monitor reset releases without the power-on delay
// RULE8 - low reset pin resets device; pin flag bit 0 set on exit
// RULE9 - clock-loss time-out resets; flag bit 2 reads 1 only then
// RULE10 - writing bit 2 enables or disables the clock-loss detector
// RULE11 - internal reset sources never drive the reset pin; power-on and monitor resets here drive it low
// RULE12 - bit 5 selects comparator; low comparator output then resets
// RULE13 - comparator flag reads 1 only after a comparator reset
// RULE14 - software lets comparator settle before selecting it
// RULE15 - watchdog enabled at clock/12 after reset; overflow resets, flags
// RULE16 - flash access above user code limit resets the device
// RULE17 - blocked flash access or write without monitor also resets
// RULE18 - flash error reset sets flag bit 6
// RULE19 - writing bit 4 forces reset; bit reads 1 afterwards
// RULE20 - selected USB resets on bus reset or VBUS edge
// RULE21 - USB flag reads 1 after a USB reset
// RULE22 - USB select and flag at bit 7 of reset source register
// RULE23 - read-only watchdog flag at bit 3, set only by overflow
// RULE24 - power-on or monitor reset sets bit 1, others clear it
// RULE25 - only the causing source's flag reads 1 after release
// RULE26 - requests combine into one reset, released on the clock
`timescale 1ns/1ns
module reset_source_controller import rsc_pkg::*; #(
  parameter int POR_DELAY_CYCLES = POR_DELAY_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire sfr_bus_t sfr,
  output logic [7:0] rd_data,
  input wire logic supply_above_threshold,
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe_n,
  input wire logic comparator_out,
  input wire logic clk_probe,
  input wire logic wd_kick,
  input wire logic wd_disable,
  input wire flash_evt_t flash,
  input wire usb_evt_t usb,
  output logic core_reset,
  output logic supply_monitor_enable
);

  typedef struct packed {
    mode_t mode;
    logic [15:0] cnt;
    logic [2:0] cause;
    logic [7:0] flags;
    logic mon_en;
    logic mon_sel;
    logic cmp_sel;
    logic usb_sel;
    logic clk_en;
    logic core_rst;
    logic pin_oe_n;
    logic pin_lvl;
    logic vbus_q;
    logic [7:0] rd_data;
  } ctl_t;

  localparam ctl_t CTL_RST = '{
    mode: S_POR,
    cnt: 16'(POR_DELAY_CYCLES),
    cause: SRC_POR,
    flags: 8'h00,
    mon_en: 1'b1,
    mon_sel: 1'b1,
    cmp_sel: 1'b0,
    usb_sel: 1'b0,
    clk_en: 1'b0,
    core_rst: 1'b1,
    pin_oe_n: 1'b0,
    pin_lvl: 1'b0,
    vbus_q: 1'b0,
    rd_data: 8'h00
  };

  ctl_t st_r;
  ctl_t st_nxt;
  logic wd_ovf;
  logic clk_lost;
  logic mon_req;
  logic pin_req;
  logic cmp_req;
  logic flash_req;
  logic usb_req;
  logic sw_req;
  logic level_req;
  logic any_req;
  logic run;
  logic wr_mon;
  logic wr_src;
  logic [2:0] req_cause;

  watchdog_timer #(
    .DIV(WD_DIV),
    .TICKS(WD_TICKS)
  ) u_wd (
    .clk_sys(clk_sys),
    .srst(srst),
    .restart(st_r.core_rst),
    .kick(wd_kick),
    .disable_wd(wd_disable),
    .overflow(wd_ovf)
  );

  clock_loss_detector #(
    .TIMEOUT(CLK_LOSS_CYC)
  ) u_cl (
    .clk_sys(clk_sys),
    .srst(srst),
    .enable(st_r.clk_en),
    .clk_probe(clk_probe),
    .lost(clk_lost)
  );

  assign run = (st_r.mode == S_RUN);
  assign wr_mon = sfr.wr && (sfr.addr == ADDR_MON_CTRL) && run;
  assign wr_src = sfr.wr && (sfr.addr == ADDR_RST_SRC) && run;

  // request terms; the pin is ignored while this block drives it low
  // so that a monitor reset is never recorded as a pin reset
  assign mon_req = st_r.mon_en && st_r.mon_sel
                   && !supply_above_threshold; // RULE1 RULE4
  assign pin_req = !rst_pin_in && st_r.pin_oe_n; // RULE8
  assign cmp_req = st_r.cmp_sel && !comparator_out; // RULE12
  assign flash_req = flash.addr_over // RULE16
                     || flash.sec_block
                     || (flash.wr_attempt && !st_r.mon_en); // RULE17
  assign usb_req = st_r.usb_sel
                   && ((usb.bus_reset && usb.func_en)
                       || (usb.vbus != st_r.vbus_q)); // RULE20
  assign sw_req = wr_src && sfr.wdata[SRC_SW]; // RULE19
  assign level_req = mon_req || pin_req || cmp_req;
  assign any_req = level_req || flash_req || usb_req || sw_req
                   || wd_ovf || clk_lost; // RULE26

  // fixed priority when sources coincide, supply monitor first
  always_comb begin
    if (mon_req) begin
      req_cause = SRC_POR;
    end else if (pin_req) begin
      req_cause = SRC_PIN;
    end else if (clk_lost) begin
      req_cause = SRC_CLK; // RULE9
    end else if (flash_req) begin
      req_cause = SRC_FLASH;
    end else if (wd_ovf) begin
      req_cause = SRC_WD; // RULE15
    end else if (cmp_req) begin
      req_cause = SRC_CMP;
    end else if (sw_req) begin
      req_cause = SRC_SW;
    end else begin
      req_cause = SRC_USB;
    end
  end

  // sequencer, register writes and read port
  always_comb begin
    st_nxt = st_r;
    st_nxt.vbus_q = usb.vbus;
    st_nxt.pin_lvl = 1'b0;
    case (st_r.mode)
      S_RUN: begin
        if (any_req) begin
          st_nxt.mode = S_HOLD; // RULE26
          st_nxt.core_rst = 1'b1;
          st_nxt.cause = req_cause; // RULE13 RULE18 RULE21
          st_nxt.cnt = 16'(MIN_HOLD_CYC);
          st_nxt.pin_oe_n = !mon_req; // RULE1 RULE11
        end else begin
          if (wr_mon) begin
            st_nxt.mon_en = sfr.wdata[MON_EN_BIT]; // RULE4 RULE6
          end
          if (wr_src) begin
            // monitor select comes last in the enabling order
            st_nxt.mon_sel = sfr.wdata[SRC_POR]; // RULE4
            st_nxt.clk_en = sfr.wdata[SRC_CLK]; // RULE10
            st_nxt.cmp_sel = sfr.wdata[SRC_CMP]; // RULE12
            st_nxt.usb_sel = sfr.wdata[SRC_USB]; // RULE22
          end
        end
        if (sfr.rd && sfr.addr == ADDR_MON_CTRL) begin
          st_nxt.rd_data = {st_r.mon_en, supply_above_threshold,
                            6'h00}; // RULE5 RULE6
        end else if (sfr.rd && sfr.addr == ADDR_RST_SRC) begin
          st_nxt.rd_data = st_r.flags; // RULE23
        end else if (sfr.rd) begin
          st_nxt.rd_data = 8'h00;
        end
      end
      S_HOLD: begin
        st_nxt.core_rst = 1'b1;
        // a supply drop during another reset takes over the cause
        if (mon_req) begin
          st_nxt.cause = SRC_POR;
          st_nxt.pin_oe_n = 1'b0; // RULE1
        end
        if (st_r.cnt != 16'h0000) begin
          st_nxt.cnt = st_r.cnt - 16'h0001;
        end else if (!level_req) begin
          // monitor release needs no power-on delay
          st_nxt.mode = S_RUN; // RULE7
          st_nxt.core_rst = 1'b0; // RULE26
          st_nxt.pin_oe_n = 1'b1;
          st_nxt.flags = 8'h01 << st_r.cause; // RULE25 RULE24 RULE8
          st_nxt.cmp_sel = 1'b0;
          st_nxt.usb_sel = 1'b0;
          st_nxt.clk_en = 1'b0;
        end
      end
      S_POR: begin
        st_nxt.core_rst = 1'b1;
        st_nxt.pin_oe_n = 1'b0;
        if (st_r.cnt != 16'h0000) begin
          st_nxt.cnt = st_r.cnt - 16'h0001;
        end else begin
          st_nxt.mode = S_RUN;
          st_nxt.core_rst = 1'b0;
          st_nxt.pin_oe_n = 1'b1;
          st_nxt.flags = 8'h01 << SRC_POR; // RULE24
        end
      end
      default: begin
        st_nxt = CTL_RST;
      end
    endcase
  end

  // srst is the power-on reset: the only place mon_en is forced
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= CTL_RST; // RULE2
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data = st_r.rd_data;
  assign rst_pin_out = st_r.pin_lvl;
  assign rst_pin_oe_n = st_r.pin_oe_n;
  assign core_reset = st_r.core_rst;
  assign supply_monitor_enable = st_r.mon_en;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  a_mon_holds_core: assert property ( // RULE1
    run && mon_req |=> (core_reset && !rst_pin_oe_n) [*2])
    else $error("supply drop did not hold core and pin");

  a_mon_en_kept: assert property ( // RULE2
    !wr_mon |=> st_r.mon_en == $past(st_r.mon_en))
    else $error("monitor enable changed without a write");

  a_quiet_run: assert property ( // RULE4
    run && !any_req |=> !core_reset)
    else $error("reset entered with no request");

  a_mon_read: assert property ( // RULE5
    run && sfr.rd && sfr.addr == ADDR_MON_CTRL
    |=> rd_data == {$past(st_r.mon_en), $past(supply_above_threshold),
                    6'h00})
    else $error("monitor control read wrong");

  a_no_por_delay: assert property ( // RULE7
    st_r.mode == S_HOLD && st_r.cause == SRC_POR && st_r.cnt == 16'h0000
    && !level_req |=> !core_reset)
    else $error("monitor reset release delayed");

  a_pin_flag: assert property ( // RULE8
    $fell(core_reset) && $past(st_r.cause) == SRC_PIN
    && $past(st_r.mode) == S_HOLD |-> rst_src_flags_ok(8'h01))
    else $error("pin flag not alone after pin reset");

  a_pin_quiet: assert property ( // RULE11
    st_r.mode == S_HOLD && st_r.cause != SRC_POR |-> rst_pin_oe_n)
    else $error("internal reset drove the pin");

  a_one_flag: assert property ( // RULE25
    !core_reset |-> $onehot(st_r.flags))
    else $error("more than one source flag set");

  a_sw_force: assert property ( // RULE19
    run && sw_req && !(mon_req || pin_req || clk_lost || flash_req
    || wd_ovf || cmp_req) |=> core_reset ##[1:8] st_r.flags == 8'h10)
    else $error("software reset not forced or flagged");

  function automatic logic rst_src_flags_ok(input logic [7:0] want);
    rst_src_flags_ok = (st_r.flags == want);
  endfunction

  c_por_exit: cover property ($fell(core_reset) && st_r.flags == 8'h02);
  c_mon_reset: cover property (run && mon_req);
  c_sw_reset: cover property (run && sw_req);
  c_cmp_reset: cover property ($fell(core_reset) && st_r.flags == 8'h20);

endmodule

//--- verification/reset_far_side.sv
// far-side model: reset pin circuit, supply monitor, comparator, clock
`timescale 1ns/1ns
module reset_far_side (
  input wire logic clk_sys,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe_n,
  input wire logic pin_low,
  input wire logic supply_low,
  input wire logic cmp_low,
  input wire logic clk_stop,
  output logic rst_pin_in,
  output logic supply_above_threshold,
  output logic comparator_out,
  output logic clk_probe
);
  // pin has a pull-up; either party may pull it low
  assign rst_pin_in = (!rst_pin_oe_n) ? rst_pin_out : !pin_low;
  // monitor output, 1 while the supply is above threshold
  assign supply_above_threshold = !supply_low;
  // low output means positive input below negative input
  assign comparator_out = !cmp_low;
  // probe toggles each cycle unless held stuck to fake a dead clock
  logic probe_q = 1'b0;
  always @(posedge clk_sys) begin
    if (!clk_stop) begin
      probe_q <= !probe_q;
    end
  end
  assign clk_probe = probe_q;
endmodule

//--- verification/tb_top.sv
// self-checking bench for the reset source controller
`timescale 1ns/1ns
module tb_top;
  import rsc_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  sfr_bus_t sfr = '0;
  flash_evt_t flash = '0;
  usb_evt_t usb = '0;
  logic wd_kick = 1'b0;
  logic kick_on = 1'b1;
  logic wd_disable = 1'b0;
  logic pin_low = 1'b0;
  logic supply_low = 1'b0;
  logic cmp_low = 1'b0;
  logic clk_stop = 1'b0;
  logic [7:0] rd_data;
  logic rst_pin_in, rst_pin_out, rst_pin_oe_n, supply_above_threshold;
  logic comparator_out, clk_probe, core_reset, supply_monitor_enable;
  logic pin_drv;
  logic [7:0] got;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;

  reset_source_controller #(.POR_DELAY_CYCLES(20)) dut_u (
    .clk_sys(clk_sys),
    .srst(srst),
    .sfr(sfr),
    .rd_data(rd_data),
    .supply_above_threshold(supply_above_threshold),
    .rst_pin_in(rst_pin_in),
    .rst_pin_out(rst_pin_out),
    .rst_pin_oe_n(rst_pin_oe_n),
    .comparator_out(comparator_out),
    .clk_probe(clk_probe),
    .wd_kick(wd_kick),
    .wd_disable(wd_disable),
    .flash(flash),
    .usb(usb),
    .core_reset(core_reset),
    .supply_monitor_enable(supply_monitor_enable)
  );

  reset_far_side far_u (
    .clk_sys(clk_sys),
    .rst_pin_out(rst_pin_out),
    .rst_pin_oe_n(rst_pin_oe_n),
    .pin_low(pin_low),
    .supply_low(supply_low),
    .cmp_low(cmp_low),
    .clk_stop(clk_stop),
    .rst_pin_in(rst_pin_in),
    .supply_above_threshold(supply_above_threshold),
    .comparator_out(comparator_out),
    .clk_probe(clk_probe)
  );

  // 50 MHz system clock
  always #10 clk_sys = ~clk_sys;

  // periodic kick keeps the watchdog quiet unless a test stops it
  always @(negedge clk_sys) begin
    cyc <= cyc + 1;
    wd_kick <= kick_on && (cyc % 64 == 0);
  end

  task automatic results();
    $display("comparisons=%0d failures=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one-cycle strobes launched from the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr.wr = 1'b1;
    sfr.addr = a;
    sfr.wdata = d;
    @(negedge clk_sys);
    sfr.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge clk_sys);
    sfr.rd = 1'b1;
    sfr.addr = a;
    @(negedge clk_sys);
    sfr.rd = 1'b0;
    got = rd_data;
  endtask

  // bounded wait for a reset pulse; notes whether the pin got driven
  task automatic wait_rst(input int lim);
    int n;
    n = 0;
    pin_drv = 1'b0;
    while (core_reset !== 1'b1 && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    while (core_reset !== 1'b0 && n < lim) begin
      if (rst_pin_oe_n === 1'b0) pin_drv = 1'b1;
      @(negedge clk_sys);
      n++;
    end
    chk1(n < lim, 1'b1);
  endtask

  task automatic hit(input logic [7:0] e);
    wait_rst(4000);
    rd(ADDR_RST_SRC);
    chk8(got, e);
  endtask

  // hang guard, well beyond the longest sequence
  initial begin
    repeat (30000) @(posedge clk_sys);
    failures++;
    results();
  end

  initial begin
    repeat (2) @(negedge clk_sys);
    srst = 1'b0;
    wait_rst(100);
    rd(ADDR_RST_SRC);
    chk8(got, 8'h02);
    rd(ADDR_MON_CTRL);
    chk8(got, 8'hC0);
    wr(ADDR_MON_CTRL, 8'h3F);
    rd(ADDR_MON_CTRL);
    chk8(got, 8'h40);
    chk1(supply_monitor_enable, 1'b0);
    rd(8'h10);
    chk8(got, 8'h00);
    wr(ADDR_RST_SRC, 8'h10);
    hit(8'h10);
    chk1(pin_drv, 1'b0);
    rd(ADDR_MON_CTRL);
    chk8(got, 8'h40);
    // each flash fault; the write attempt counts as the monitor is off
    for (int i = 0; i < 3; i++) begin
      @(negedge clk_sys);
      flash = flash_evt_t'(3'b001 << i);
      @(negedge clk_sys);
      flash = '0;
      hit(8'h40);
      chk1(pin_drv, 1'b0);
    end
    @(negedge clk_sys);
    pin_low = 1'b1;
    repeat (8) @(negedge clk_sys);
    pin_low = 1'b0;
    hit(8'h01);
    // comparator low before selection must be harmless
    cmp_low = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk1(core_reset, 1'b0);
    cmp_low = 1'b0;
    wr(ADDR_RST_SRC, 8'h20);
    cmp_low = 1'b1;
    repeat (6) @(negedge clk_sys);
    cmp_low = 1'b0;
    hit(8'h20);
    chk1(pin_drv, 1'b0);
    // detector switched on then off: a stuck clock is ignored
    wr(ADDR_RST_SRC, 8'h04);
    wr(ADDR_RST_SRC, 8'h00);
    clk_stop = 1'b1;
    repeat (150) @(negedge clk_sys);
    chk1(core_reset, 1'b0);
    wr(ADDR_RST_SRC, 8'h04);
    hit(8'h04);
    chk1(pin_drv, 1'b0);
    clk_stop = 1'b0;
    // a disabled watchdog stays quiet, the next reset re-enables it
    wd_disable = 1'b1;
    kick_on = 1'b0;
    @(negedge clk_sys);
    wd_disable = 1'b0;
    repeat (3300) @(negedge clk_sys);
    chk1(core_reset, 1'b0);
    wr(ADDR_RST_SRC, 8'h10);
    hit(8'h10);
    hit(8'h08);
    chk1(pin_drv, 1'b0);
    kick_on = 1'b1;
    wr(ADDR_RST_SRC, 8'h80);
    usb.vbus = 1'b1;
    hit(8'h80);
    chk1(pin_drv, 1'b0);
    // bus reset signalling counts only with the function controller on
    wr(ADDR_RST_SRC, 8'h80);
    usb.bus_reset = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk1(core_reset, 1'b0);
    usb.func_en = 1'b1;
    hit(8'h80);
    usb.bus_reset = 1'b0;
    // enable first, select afterwards, then brown out
    wr(ADDR_MON_CTRL, 8'h80);
    rd(ADDR_MON_CTRL);
    chk8(got, 8'hC0);
    wr(ADDR_RST_SRC, 8'h02);
    supply_low = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk1(core_reset, 1'b1);
    chk1(rst_pin_oe_n, 1'b0);
    chk1(rst_pin_out, 1'b0);
    repeat (6) @(negedge clk_sys);
    supply_low = 1'b0;
    repeat (8) @(negedge clk_sys);
    chk1(core_reset, 1'b0);
    rd(ADDR_RST_SRC);
    chk8(got, 8'h02);
    results();
  end
endmodule
